/* src/uart_frame_control_and_data_buffer.v */
// What this block does
// - extra bit sends the transmit extra-bit control; ignored while parity enabled
// - received extra-bit status shows extra bit, else the first stop bit level
// - with parity enabled the received extra-bit status has no meaning
// - transmit flag set at start of stop bit; only software clears it
// - receive flag set when the stop bit is sampled; only software clears it
// - receive flag holds while fifo has data; clear works only once empty
// - with interrupt enabled, either flag set raises the interrupt request
// - multiprocessor filter: receive flag needs stop bit high, extra-bit enable and extra bit high
// - parity type: 00 odd, 01 even, 10 mark, 11 space
// - parity enable generates parity on transmit and checks it on receive
// - data length field: 00 five up to 11 eight data bits
// - extra-bit enable appends the transmit extra bit after the data
// - long stop: two bit times, or 1.5 with five data bits
// - writing the data buffer while idle loads the shifter and starts transmission
// - reading the data buffer returns the receive side, not the shifter
// - receiver enable low accepts no new characters; fifo stays readable
// - store only if fifo not full and stop high; full fifo sets overrun
// - parity mismatch sets a sticky parity error flag cleared by software
`timescale 1ns/1ps
`include "uart_frame_control_regs.vh"

module uart_frame_control_and_data_buffer #(
    parameter OVERSAMPLE = `OVERSAMPLE_DEFAULT,
    parameter FIFO_DEPTH = `RX_FIFO_DEPTH_DEFAULT
) (
    // clock, reset, enable
    input wire core_clk,
    input wire rst,
    input wire clk_en,
    // special-function-register bus
    input wire [7:0] sfr_addr,
    input wire sfr_wr,
    input wire sfr_rd,
    input wire [7:0] sfr_wdata,
    output reg [7:0] sfr_rdata,
    // bit timing and interrupt control
    input wire baud_tick,
    input wire irq_enable,
    output reg irq,
    // serial lines
    input wire rxd,
    output reg txd
);

    // counts worked out as integers, then cut to the counter widths on purpose
    localparam integer OS_LAST_I = OVERSAMPLE - 1;
    localparam integer OS_HALF_LAST_I = OVERSAMPLE / 2 - 1;
    localparam integer STOP_ONE_I = OVERSAMPLE - 1;
    localparam integer STOP_ONE_HALF_I = (OVERSAMPLE * 3) / 2 - 1;
    localparam integer STOP_TWO_I = OVERSAMPLE * 2 - 1;
    localparam integer FIFO_LAST_I = FIFO_DEPTH - 1;
    localparam integer FIFO_FULL_I = FIFO_DEPTH;
    localparam [7:0] OS_LAST = OS_LAST_I[7:0];
    localparam [7:0] OS_HALF_LAST = OS_HALF_LAST_I[7:0];
    localparam [7:0] STOP_ONE = STOP_ONE_I[7:0];
    localparam [7:0] STOP_ONE_HALF = STOP_ONE_HALF_I[7:0];
    localparam [7:0] STOP_TWO = STOP_TWO_I[7:0];
    localparam [1:0] FIFO_LAST = FIFO_LAST_I[1:0];
    localparam [1:0] FIFO_FULL = FIFO_FULL_I[1:0];

    localparam [2:0] ST_IDLE = 3'd0;
    localparam [2:0] ST_START = 3'd1;
    localparam [2:0] ST_DATA = 3'd2;
    localparam [2:0] ST_EXTRA = 3'd3;
    localparam [2:0] ST_STOP = 3'd4;

    // register state
    reg [7:0] mode_r;
    reg ovr_r, perr_r, ren_r, tbx_r, ti_r, ri_r;
    reg [8:0] latch_r;

    // frame format decode
    wire mce = mode_r[`MOD_MULTIPROC];
    wire [1:0] ptype = mode_r[`MOD_PTYPE_HI:`MOD_PTYPE_LO];
    wire pe = mode_r[`MOD_PARITY_EN];
    wire [1:0] dlen = mode_r[`MOD_DLEN_HI:`MOD_DLEN_LO];
    wire xbe = mode_r[`MOD_EXTRA_EN];
    wire sbl = mode_r[`MOD_STOP_LEN];
    wire [2:0] nbits_m1 = `DLEN_MIN_MINUS1 + {1'b0, dlen};
    wire has_extra = pe | xbe;
    wire [7:0] len_mask = 8'hff >> (`DLEN_MAX - dlen);
    wire [7:0] stop_last = !sbl ? STOP_ONE :
        (dlen == `DLEN_FIVE) ? STOP_ONE_HALF : STOP_TWO;

    function par_bit;
        input [1:0] pt;
        input [7:0] d;
        begin
            case (pt)
                `PTYPE_ODD: par_bit = ~^d;
                `PTYPE_EVEN: par_bit = ^d;
                `PTYPE_MARK: par_bit = 1'b1;
                default: par_bit = 1'b0;
            endcase
        end
    endfunction

    // bus decode
    wire wr_ctl = sfr_wr && (sfr_addr == `ADDR_CONTROL_FLAGS);
    wire wr_mode = sfr_wr && (sfr_addr == `ADDR_FRAME_MODE);
    wire wr_buf = sfr_wr && (sfr_addr == `ADDR_DATA_BUFFER);
    wire rd_buf = sfr_rd && (sfr_addr == `ADDR_DATA_BUFFER);

    // ---------------- transmitter ----------------
    reg [2:0] tx_state_r;
    reg [7:0] tx_tick_r;
    reg [2:0] tx_bit_r;
    reg [7:0] tx_shift_r;
    reg tx_extra_r;
    reg ti_set;
    wire tx_bit_end = baud_tick && (tx_tick_r == OS_LAST);
    wire tx_idle = (tx_state_r == ST_IDLE);

    always @(posedge core_clk) begin
        if (rst) begin
            tx_state_r <= ST_IDLE;
            tx_tick_r <= 8'h00;
            tx_bit_r <= 3'd0;
            tx_shift_r <= 8'h00;
            tx_extra_r <= 1'b0;
            txd <= 1'b1;
            ti_set <= 1'b0;
        end else if (clk_en) begin
            ti_set <= 1'b0;
            if (!tx_idle && baud_tick)
                tx_tick_r <= tx_bit_end ? 8'h00 : tx_tick_r + 8'h01;
            case (tx_state_r)
                ST_IDLE: begin
                    // a write while busy is dropped; software watches the empty flag
                    if (wr_buf) begin
                        tx_shift_r <= sfr_wdata & len_mask;
                        tx_extra_r <= pe ? par_bit(ptype, sfr_wdata & len_mask)
                            : tbx_r;
                        tx_tick_r <= 8'h00;
                        txd <= 1'b0;
                        tx_state_r <= ST_START;
                    end
                end
                ST_START: begin
                    if (tx_bit_end) begin
                        txd <= tx_shift_r[0];
                        tx_bit_r <= 3'd0;
                        tx_state_r <= ST_DATA;
                    end
                end
                ST_DATA: begin
                    if (tx_bit_end) begin
                        if (tx_bit_r == nbits_m1) begin
                            if (has_extra) begin
                                txd <= tx_extra_r;
                                tx_state_r <= ST_EXTRA;
                            end else begin
                                txd <= 1'b1;
                                ti_set <= 1'b1;
                                tx_state_r <= ST_STOP;
                            end
                        end else begin
                            txd <= tx_shift_r[1];
                            tx_shift_r <= tx_shift_r >> 1;
                            tx_bit_r <= tx_bit_r + 3'd1;
                        end
                    end
                end
                ST_EXTRA: begin
                    if (tx_bit_end) begin
                        txd <= 1'b1;
                        ti_set <= 1'b1;
                        tx_state_r <= ST_STOP;
                    end
                end
                ST_STOP: begin
                    // the stop phase runs on its own count to stop_last, past one bit time for long stop
                    if (baud_tick) begin
                        if (tx_tick_r == stop_last) begin
                            tx_tick_r <= 8'h00;
                            tx_state_r <= ST_IDLE;
                        end else begin
                            tx_tick_r <= tx_tick_r + 8'h01;
                        end
                    end
                end
                default: tx_state_r <= ST_IDLE;
            endcase
        end
    end

    // ---------------- receiver ----------------
    reg rx_meta_r, rx_sync_r, rx_prev_r;
    reg [2:0] rx_state_r;
    reg [7:0] rx_tick_r;
    reg [2:0] rx_bit_r;
    reg [7:0] rx_shift_r;
    reg rx_extra_r;
    wire rx_bit_end = baud_tick && (rx_tick_r == OS_LAST);
    wire commit = (rx_state_r == ST_STOP) && rx_bit_end;
    wire [7:0] rx_data = rx_shift_r >> (`DATA_TOP_INDEX - nbits_m1);

    always @(posedge core_clk) begin
        if (rst) begin
            rx_meta_r <= 1'b1;
            rx_sync_r <= 1'b1;
            rx_prev_r <= 1'b1;
            rx_state_r <= ST_IDLE;
            rx_tick_r <= 8'h00;
            rx_bit_r <= 3'd0;
            rx_shift_r <= 8'h00;
            rx_extra_r <= 1'b0;
        end else if (clk_en) begin
            rx_meta_r <= rxd;
            rx_sync_r <= rx_meta_r;
            rx_prev_r <= rx_sync_r;
            if (rx_state_r != ST_IDLE && baud_tick)
                rx_tick_r <= rx_bit_end ? 8'h00 : rx_tick_r + 8'h01;
            case (rx_state_r)
                ST_IDLE: begin
                    // a frame already under way finishes even if the receiver is turned off
                    if (ren_r && rx_prev_r && !rx_sync_r) begin
                        rx_tick_r <= 8'h00;
                        rx_state_r <= ST_START;
                    end
                end
                ST_START: begin
                    // recentre on mid-bit; a glitch shorter than half a bit is dropped
                    if (baud_tick && rx_tick_r == OS_HALF_LAST) begin
                        rx_tick_r <= 8'h00;
                        rx_bit_r <= 3'd0;
                        rx_state_r <= rx_sync_r ? ST_IDLE : ST_DATA;
                    end
                end
                ST_DATA: begin
                    if (rx_bit_end) begin
                        rx_shift_r <= {rx_sync_r, rx_shift_r[7:1]};
                        rx_bit_r <= rx_bit_r + 3'd1;
                        if (rx_bit_r == nbits_m1)
                            rx_state_r <= has_extra ? ST_EXTRA : ST_STOP;
                    end
                end
                ST_EXTRA: begin
                    if (rx_bit_end) begin
                        rx_extra_r <= rx_sync_r;
                        rx_state_r <= ST_STOP;
                    end
                end
                ST_STOP: begin
                    if (rx_bit_end)
                        rx_state_r <= ST_IDLE;
                end
                default: rx_state_r <= ST_IDLE;
            endcase
        end
    end

    // ---------------- receive fifo ----------------
    reg [8:0] fifo_mem [0:FIFO_DEPTH-1];
    reg [1:0] wr_ptr_r, rd_ptr_r, count_r;
    wire stop_ok = rx_sync_r;
    wire full = (count_r == FIFO_FULL);
    wire push = commit && stop_ok && !full;
    wire ovr_set = commit && stop_ok && full;
    wire pop = rd_buf && (count_r != 2'd0);
    wire [1:0] count_nxt = count_r + {1'b0, push} - {1'b0, pop};
    wire rbx_in = xbe ? rx_extra_r : stop_ok;
    wire perr_set = push && pe && (rx_extra_r != par_bit(ptype, rx_data));
    wire ri_set = push && (!mce || (xbe && rx_extra_r));
    wire [8:0] head = fifo_mem[rd_ptr_r];
    // an empty fifo shows the last character read again, held in the latch
    wire [8:0] shown = (count_r != 2'd0) ? head : latch_r;

    genvar gi;
    generate
        for (gi = 0; gi < FIFO_DEPTH; gi = gi + 1) begin : g_fifo
            always @(posedge core_clk) begin
                if (rst)
                    fifo_mem[gi] <= 9'h000;
                else if (clk_en && push && wr_ptr_r == gi)
                    fifo_mem[gi] <= {rbx_in, rx_data};
            end
        end
    endgenerate

    always @(posedge core_clk) begin
        if (rst) begin
            wr_ptr_r <= 2'd0;
            rd_ptr_r <= 2'd0;
            count_r <= 2'd0;
            latch_r <= {1'b0, `DATA_BUFFER_RESET};
        end else if (clk_en) begin
            if (push)
                wr_ptr_r <= (wr_ptr_r == FIFO_LAST) ? 2'd0 : wr_ptr_r + 2'd1;
            if (pop) begin
                rd_ptr_r <= (rd_ptr_r == FIFO_LAST) ? 2'd0 : rd_ptr_r + 2'd1;
                latch_r <= head;
            end
            count_r <= count_nxt;
        end
    end

    // ---------------- registers and bus ----------------
    always @(posedge core_clk) begin
        if (rst) begin
            mode_r <= `FRAME_MODE_RESET;
            ovr_r <= 1'b0;
            perr_r <= 1'b0;
            ren_r <= 1'b0;
            tbx_r <= 1'b0;
            ti_r <= 1'b0;
            ri_r <= 1'b0;
            sfr_rdata <= 8'h00;
            irq <= 1'b0;
        end else if (clk_en) begin
            if (wr_mode)
                mode_r <= sfr_wdata;
            if (wr_ctl) begin
                ren_r <= sfr_wdata[`CTL_RX_ENABLE];
                tbx_r <= sfr_wdata[`CTL_TX_EXTRA];
            end
            // hardware sets win over a software write in the same cycle
            ovr_r <= ovr_set | (wr_ctl ? sfr_wdata[`CTL_OVERRUN] : ovr_r);
            perr_r <= perr_set | (wr_ctl ? sfr_wdata[`CTL_PARITY_ERR] : perr_r);
            ti_r <= ti_set | (wr_ctl ? sfr_wdata[`CTL_TX_DONE] : ti_r);
            // a clear of rx done is refused while a character still waits in the fifo
            ri_r <= ri_set | (wr_ctl ? (sfr_wdata[`CTL_RX_DONE] | (count_nxt != 2'd0))
                : ri_r);
            irq <= irq_enable && (ti_r || ri_r);
            if (sfr_rd) begin
                case (sfr_addr)
                    `ADDR_CONTROL_FLAGS:
                        // the extra-bit status is meaningless while parity is on
                        sfr_rdata <= {ovr_r, perr_r, tx_idle, ren_r, tbx_r,
                            shown[8], ti_r, ri_r};
                    `ADDR_FRAME_MODE: sfr_rdata <= mode_r;
                    `ADDR_DATA_BUFFER: sfr_rdata <= shown[7:0];
                    default: sfr_rdata <= 8'h00;
                endcase
            end
        end
    end

endmodule // uart_frame_control_and_data_buffer

/* src/uart_frame_control_regs.vh */
`ifndef UART_FRAME_CONTROL_REGS_VH
`define UART_FRAME_CONTROL_REGS_VH

// register addresses on the special-function-register bus
`define ADDR_CONTROL_FLAGS 8'h98
`define ADDR_DATA_BUFFER 8'h99
`define ADDR_FRAME_MODE 8'ha9

// serial_control_flags bit positions
`define CTL_OVERRUN 7
`define CTL_PARITY_ERR 6
`define CTL_TX_EMPTY 5
`define CTL_RX_ENABLE 4
`define CTL_TX_EXTRA 3
`define CTL_RX_EXTRA 2
`define CTL_TX_DONE 1
`define CTL_RX_DONE 0

// serial_frame_mode bit positions
`define MOD_MULTIPROC 7
`define MOD_PTYPE_HI 6
`define MOD_PTYPE_LO 5
`define MOD_PARITY_EN 4
`define MOD_DLEN_HI 3
`define MOD_DLEN_LO 2
`define MOD_EXTRA_EN 1
`define MOD_STOP_LEN 0

// reset values
`define FRAME_MODE_RESET 8'h0c
`define DATA_BUFFER_RESET 8'h00

// parity type encodings
`define PTYPE_ODD 2'b00
`define PTYPE_EVEN 2'b01
`define PTYPE_MARK 2'b10
`define PTYPE_SPACE 2'b11

// data length encodings and the smallest character
`define DLEN_FIVE 2'b00
`define DLEN_MIN_MINUS1 3'd4
`define DATA_TOP_INDEX 3'd7
`define DLEN_MAX 2'd3

// oversampling and fifo defaults
`define OVERSAMPLE_DEFAULT 16
`define RX_FIFO_DEPTH_DEFAULT 3

`endif

/* testbench/uart_frame_control_and_data_buffer_tb_top.sv */
`timescale 1ns/1ps
`include "uart_frame_control_regs.vh"
module uart_frame_control_and_data_buffer_tb_top;
    localparam BIT_CYC = 32;
    localparam [7:0] CTL = `ADDR_CONTROL_FLAGS;
    localparam [7:0] BUF = `ADDR_DATA_BUFFER;
    localparam [7:0] MOD = `ADDR_FRAME_MODE;
    reg core_clk = 1'b0;
    reg rst = 1'b1;
    reg [7:0] sfr_addr = 8'h00;
    reg sfr_wr = 1'b0;
    reg sfr_rd = 1'b0;
    reg [7:0] sfr_wdata = 8'h00;
    reg baud_tick = 1'b0;
    reg irq_enable = 1'b0;
    wire [7:0] sfr_rdata;
    wire irq;
    wire rxd;
    wire txd;
    integer err_count = 0;
    integer checks = 0;
    integer i;
    reg [7:0] v;
    reg [11:0] fr;
    reg ok;
    reg p;

    uart_frame_control_and_data_buffer u_dut (
        .core_clk(core_clk), .rst(rst), .clk_en(1'b1), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .baud_tick(baud_tick),
        .irq_enable(irq_enable), .irq(irq), .rxd(rxd), .txd(txd));
    uart_remote_model #(.BIT_CYC(BIT_CYC)) u_far (.core_clk(core_clk), .txd(txd), .rxd(rxd));

    initial begin
        forever #10 core_clk = ~core_clk;
    end
    // a tick every second clock: 32 clocks per bit at 16x oversampling
    always @(posedge core_clk) #1 baud_tick = ~baud_tick;

    task chk(input [11:0] seen, input [11:0] exp);
        begin
            checks = checks + 1;
            if (seen !== exp) begin
                err_count = err_count + 1;
                $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task wr(input [7:0] a, input [7:0] d);
        begin
            @(posedge core_clk);
            #1 sfr_addr = a;
            sfr_wdata = d;
            sfr_wr = 1'b1;
            @(posedge core_clk);
            #1 sfr_wr = 1'b0;
        end
    endtask
    task rd(input [7:0] a);
        begin
            @(posedge core_clk);
            #1 sfr_addr = a;
            sfr_rd = 1'b1;
            @(posedge core_clk);
            #1 sfr_rd = 1'b0;
            v = sfr_rdata;
        end
    endtask
    task ck(input [7:0] a, input [7:0] e);
        begin
            rd(a);
            chk(v, e);
        end
    endtask
    task tx(input [7:0] d, input integer n, input [11:0] e);
        begin
            wr(BUF, d);
            u_far.get(n, fr, ok);
            chk(ok, 1'b1);
            if (!ok) results;
            chk(fr, e);
        end
    endtask
    task s_reset;
        begin
            ck(CTL, 8'h20);
            ck(MOD, `FRAME_MODE_RESET);
            ck(BUF, `DATA_BUFFER_RESET);
            ck(8'h55, 8'h00);
            @(posedge core_clk);
            #1 sfr_addr = MOD;
            sfr_wdata = 8'h1d;
            sfr_wr = 1'b1;
            @(posedge core_clk);
            #1 sfr_wr = 1'b0;
            sfr_rd = 1'b1;
            @(posedge core_clk);
            #1 sfr_rd = 1'b0;
            chk(sfr_rdata, 8'h1d);
        end
    endtask
    task s_tx_long_stop;
        begin
            irq_enable = 1'b1;
            wr(MOD, 8'h0d);
            repeat (400) @(posedge core_clk);
            tx(8'ha5, 10, {3'b001, 8'ha5, 1'b0});
            ck(CTL, 8'h02);
            chk(irq, 1'b1);
            #(20 * BIT_CYC);
            ck(CTL, 8'h22);
            irq_enable = 1'b0;
            #40;
            chk(irq, 1'b0);
            irq_enable = 1'b1;
            wr(CTL, 8'h00);
            #40;
            chk(irq, 1'b0);
        end
    endtask
    task s_tx_parity;
        begin
            wr(CTL, 8'h08);
            for (i = 0; i < 4; i = i + 1) begin
                wr(MOD, {1'b0, i[1:0], 5'b10001});
                p = (i == 0) ? ~^5'h13 : (i == 1) ? ^5'h13 : (i == 2);
                tx(8'hf3, 8, {4'h1, p, 5'h13, 1'b0});
                ck(CTL, 8'h2a);
            end
        end
    endtask
    task s_tx_extra;
        begin
            wr(MOD, 8'h0a);
            for (i = 0; i < 2; i = i + 1) begin
                wr(CTL, {4'h0, i[0], 3'b000});
                tx(8'h5a, 10, {2'b01, i[0], 7'h5a, 1'b0});
            end
            wr(CTL, 8'h10);
        end
    endtask
    task s_rx_fifo;
        begin
            wr(MOD, 8'h0c);
            u_far.put({3'b001, 8'h3c, 1'b0}, 10);
            ck(CTL, 8'h35);
            ck(BUF, 8'h3c);
            wr(CTL, 8'h10);
            ck(CTL, 8'h34);
            for (i = 1; i < 5; i = i + 1) u_far.put({3'b001, i[7:0], 1'b0}, 10);
            ck(CTL, 8'hb5);
            wr(CTL, 8'h10);
            ck(CTL, 8'h35);
            for (i = 1; i < 4; i = i + 1) ck(BUF, i[7:0]);
            wr(CTL, 8'h10);
            ck(CTL, 8'h34);
            u_far.put({3'b000, 8'h77, 1'b0}, 10);
            ck(CTL, 8'h34);
        end
    endtask
    task s_rx_parity_filter;
        begin
            wr(MOD, 8'h3c);
            for (i = 0; i < 2; i = i + 1) begin
                u_far.put({2'b01, i[0], 8'h01, 1'b0}, 11);
                rd(CTL);
                chk(v & 8'hfb, i ? 8'h31 : 8'h71);
                ck(BUF, 8'h01);
                wr(CTL, 8'h10);
            end
            wr(MOD, 8'h8e);
            u_far.put({3'b010, 8'h42, 1'b0}, 11);
            ck(CTL, 8'h30);
            u_far.put({3'b011, 8'h43, 1'b0}, 11);
            ck(CTL, 8'h31);
            ck(BUF, 8'h42);
            ck(CTL, 8'h35);
            ck(BUF, 8'h43);
            wr(CTL, 8'h00);
            u_far.put({3'b001, 8'h66, 1'b1}, 11);
            u_far.put({3'b011, 8'h66, 1'b0}, 11);
            ck(CTL, 8'h24);
        end
    endtask
    task results;
        begin
            $display("checks %0d err_count %0d", checks, err_count);
            if (err_count == 0 && checks > 0) begin
                $display("verification passed");
            end else begin
                $display("verification failed");
            end
            $finish;
        end
    endtask

    initial begin
        repeat (6) @(posedge core_clk);
        #1 rst = 1'b0;
        s_reset;
        s_tx_long_stop;
        s_tx_parity;
        s_tx_extra;
        s_rx_fifo;
        s_rx_parity_filter;
        results;
    end
endmodule // uart_frame_control_and_data_buffer_tb_top

/* testbench/uart_frame_control_sva.sv */
`timescale 1ns/1ps
`include "uart_frame_control_regs.vh"
module uart_frame_control_sva (
    // clock and reset
    input wire core_clk,
    input wire rst,
    input wire clk_en,
    // register bus
    input wire [7:0] sfr_addr,
    input wire sfr_wr,
    input wire sfr_rd,
    input wire [7:0] sfr_wdata,
    input wire [7:0] sfr_rdata,
    // timing, interrupt and serial lines
    input wire baud_tick,
    input wire irq_enable,
    input wire irq,
    input wire rxd,
    input wire txd
);
    // ticks of unbroken high line; longer than any high run inside a frame
    reg [7:0] hi_cnt;
    wire idle_long = hi_cnt >= 8'd192;
    wire buf_wr = sfr_wr && clk_en && sfr_addr == `ADDR_DATA_BUFFER;
    wire ctl_rd = sfr_rd && clk_en && sfr_addr == `ADDR_CONTROL_FLAGS;
    wire mapped = sfr_addr == `ADDR_CONTROL_FLAGS || sfr_addr == `ADDR_DATA_BUFFER
        || sfr_addr == `ADDR_FRAME_MODE;
    always @(posedge core_clk) begin
        if (rst || !txd) begin
            hi_cnt <= 8'd0;
        end else if (baud_tick && clk_en && hi_cnt != 8'hff) begin
            hi_cnt <= hi_cnt + 8'd1;
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    property p_reset_idle; disable iff (1'b0) rst |=> txd && !irq && sfr_rdata == 8'h00; endproperty
    a_reset_idle: assert property (p_reset_idle) else $error("reset state wrong");
    property p_irq_masked; !irq_enable && clk_en |=> !irq; endproperty
    a_irq_masked: assert property (p_irq_masked) else $error("irq while disabled");
    property p_rdata_hold; !sfr_rd |=> $stable(sfr_rdata); endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
    property p_unmapped_zero; sfr_rd && clk_en && !mapped |=> sfr_rdata == 8'h00; endproperty
    a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read nonzero");
    property p_write_starts; buf_wr && idle_long |-> ##[1:2] !txd; endproperty
    a_write_starts: assert property (p_write_starts) else $error("no start bit");
    property p_start_needs_write; $fell(txd) && idle_long |-> $past(buf_wr) || $past(buf_wr, 2);
    endproperty
    a_start_needs_write: assert property (p_start_needs_write) else $error("start unasked");
    property p_idle_empty; ctl_rd && idle_long |=> sfr_rdata[5]; endproperty
    a_idle_empty: assert property (p_idle_empty) else $error("idle but not empty");
    property p_busy_flag; ctl_rd && !txd |=> !sfr_rdata[5]; endproperty
    a_busy_flag: assert property (p_busy_flag) else $error("busy but empty");
    property p_mode_readback;
        sfr_wr && sfr_addr == `ADDR_FRAME_MODE ##1 sfr_rd && !sfr_wr && sfr_addr == `ADDR_FRAME_MODE
        |=> sfr_rdata == $past(sfr_wdata, 2);
    endproperty
    a_mode_readback: assert property (p_mode_readback) else $error("mode readback wrong");
endmodule // uart_frame_control_sva

bind uart_frame_control_and_data_buffer uart_frame_control_sva u_sva (
    .core_clk(core_clk), .rst(rst), .clk_en(clk_en), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .baud_tick(baud_tick),
    .irq_enable(irq_enable), .irq(irq), .rxd(rxd), .txd(txd));

/* testbench/uart_remote_model.sv */
`timescale 1ns/1ps
module uart_remote_model #(
    parameter BIT_CYC = 32
) (
    // clock
    input wire core_clk,
    // serial lines seen from the far end
    input wire txd,
    output reg rxd
);
    // callers enter 1 ns after an edge; fixed delays keep that offset away from the edge
    initial rxd = 1'b1;
    task put(input [11:0] b, input integer n);
        integer k;
        begin
            for (k = 0; k < n; k = k + 1) begin
                rxd = b[k];
                #(20 * BIT_CYC);
            end
            rxd = 1'b1;
            #100;
        end
    endtask
    task get(input integer n, output reg [11:0] b, output reg ok);
        integer k;
        begin
            b = 12'h000;
            for (k = 0; k < 2000 && txd; k = k + 1) @(posedge core_clk);
            ok = !txd;
            if (ok) begin
                #(10 * BIT_CYC);
                for (k = 0; k < n; k = k + 1) begin
                    b[k] = txd;
                    #(20 * BIT_CYC);
                end
            end
        end
    endtask
endmodule // uart_remote_model
